// ### logic/rcl_pkg.sv
// Shared constants and types for the reset-cause and low-voltage control block.
// Assumes a 32-bit Avalon-MM slave port with byte addressing and one clock.
package rcl_pkg;

    // Register indices; byte address on the bus is four times the index
    localparam logic [15:0] IDX_LOWVOLT_CONTROL  = 16'hff50;
    localparam logic [15:0] IDX_LEVEL_SELECT     = 16'hff51;
    localparam logic [15:0] IDX_RESET_CAUSE      = 16'hff54;
    localparam logic [15:0] IDX_LOWVOLT_BIT_WR   = 16'hff5f;

    localparam int unsigned ADDR_W = 18;
    localparam int unsigned DATA_W = 32;

    // Field positions
    localparam int unsigned CTRL_ENABLE_BIT = 7;
    localparam int unsigned CTRL_MODE_BIT   = 1;
    localparam int unsigned CTRL_FLAG_BIT   = 0;
    localparam int unsigned CAUSE_WDT_BIT   = 4;
    localparam int unsigned CAUSE_LV_BIT    = 0;
    localparam int unsigned LEVEL_W         = 4;
    localparam int unsigned BITWR_VALUE_BIT = 3;

    localparam logic [2:0] BITSEL_ENABLE = 3'h7;
    localparam logic [2:0] BITSEL_MODE   = 3'h1;

    // Reset values
    localparam logic [7:0]         CTRL_RESET  = 8'h00;
    localparam logic [7:0]         CAUSE_RESET = 8'h00;
    localparam logic [LEVEL_W-1:0] LEVEL_RESET = 4'h0;

    // Cause bits that can read as one
    localparam logic [7:0] CAUSE_MASK = 8'h11;

    // Comparator settling time software must wait after enabling
    localparam int unsigned CLK_HZ      = 50_000_000;
    localparam int unsigned SETTLE_US   = 200;
    localparam int unsigned SETTLE_CYC  = (SETTLE_US * (CLK_HZ / 1_000_000));

    typedef struct packed {
        logic enable;
        logic mode_reset;
    } rcl_ctrl_t;

    typedef struct packed {
        logic wdt;
        logic lowvolt;
    } rcl_cause_t;

    function automatic logic [ADDR_W-1:0] addr_of(input logic [15:0] idx);
        return {idx, 2'b00};
    endfunction : addr_of

endpackage : rcl_pkg

// ### logic/rcl_reset_lowvolt.sv
// Reset-cause flags and low-voltage detector control behind an Avalon-MM slave.
// Assumes the chip reset generator acts on lowvolt_reset_req and that
// por_clear_req and wdt_reset_req are synchronous to clk.
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none

module rcl_reset_lowvolt
    import rcl_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [DATA_W-1:0] writedata,
    input  wire logic [3:0]        byteenable,
    output logic      [DATA_W-1:0] readdata,
    output logic                   waitrequest,
    // Reset sources
    input  wire logic              por_clear_req,
    input  wire logic              wdt_reset_req,
    // Analogue side
    input  wire logic              comparator_below,
    output logic      [LEVEL_W-1:0] lowvolt_level_code,
    // Requests out
    output logic                   lowvolt_reset_req,
    output logic                   lowvolt_irq
);

    // Bus handshake state
    logic       ack_ff;
    logic [7:0] rdata_ff;
    logic       nxt_ack;
    logic [7:0] nxt_rdata;

    // Register state
    rcl_ctrl_t          ctrl_ff;
    rcl_cause_t         cause_ff;
    logic [LEVEL_W-1:0] level_ff;
    logic               below_flag_ff;
    logic               reset_req_ff;
    logic               irq_ff;
    rcl_ctrl_t          nxt_ctrl;
    rcl_cause_t         nxt_cause;
    logic [LEVEL_W-1:0] nxt_level;
    logic               nxt_below_flag;
    logic               nxt_reset_req;
    logic               nxt_irq;

    // Decoded strobes
    logic       req;
    logic       accept;
    logic       wr_acc;
    logic       rd_acc;
    logic       internal_clear;
    logic       lv_reset_event;
    logic       sync_below;
    logic [2:0] bit_sel;
    logic       bit_val;

    rcl_sync2 u_sync_below (
        .clk     (clk),
        .reset_n (reset_n),
        .d       (comparator_below),
        .q       (sync_below)
    );

    // One wait cycle per access so read data come from a flip-flop
    assign req         = read | write;
    assign accept      = req & ack_ff;
    assign waitrequest = req & ~ack_ff;
    assign wr_acc      = write & accept & byteenable[0];
    assign rd_acc      = read & accept;
    assign bit_sel     = writedata[2:0];
    assign bit_val     = writedata[BITWR_VALUE_BIT];

    // Any internal reset except the detector's own clears the control state
    assign internal_clear = por_clear_req | wdt_reset_req;
    assign lv_reset_event = nxt_reset_req & ~reset_req_ff;

    always_comb begin
        nxt_ack   = req & ~ack_ff;
        nxt_rdata = rdata_ff;
        if (read && !ack_ff) begin
            if (address == addr_of(IDX_RESET_CAUSE)) begin
                nxt_rdata = 8'h00;
                nxt_rdata[CAUSE_WDT_BIT] = cause_ff.wdt;
                nxt_rdata[CAUSE_LV_BIT]  = cause_ff.lowvolt;
            end else if (address == addr_of(IDX_LOWVOLT_CONTROL)) begin
                nxt_rdata = 8'h00;
                nxt_rdata[CTRL_ENABLE_BIT] = ctrl_ff.enable;
                nxt_rdata[CTRL_MODE_BIT]   = ctrl_ff.mode_reset;
                nxt_rdata[CTRL_FLAG_BIT]   = below_flag_ff;
            end else if (address == addr_of(IDX_LEVEL_SELECT)) begin
                nxt_rdata = {4'h0, level_ff};
            end else begin
                nxt_rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 8'h00;
        end else begin
            ack_ff   <= nxt_ack;
            rdata_ff <= nxt_rdata;
        end
    end

    assign readdata = {24'h000000, rdata_ff};

    // Control and level registers
    always_comb begin
        nxt_ctrl  = ctrl_ff;
        nxt_level = level_ff;
        if (internal_clear) begin
            nxt_ctrl  = rcl_ctrl_t'(CTRL_RESET[1:0]);
            nxt_level = LEVEL_RESET;
        end else if (wr_acc) begin
            if (address == addr_of(IDX_LOWVOLT_CONTROL)) begin
                // Bit 0 is the live flag, so it is never taken from the bus
                nxt_ctrl.enable     = writedata[CTRL_ENABLE_BIT];
                nxt_ctrl.mode_reset = writedata[CTRL_MODE_BIT];
            end else if (address == addr_of(IDX_LOWVOLT_BIT_WR)) begin
                if (bit_sel == BITSEL_ENABLE) begin
                    nxt_ctrl.enable = bit_val;
                end else if (bit_sel == BITSEL_MODE) begin
                    nxt_ctrl.mode_reset = bit_val;
                end
            end else if (address == addr_of(IDX_LEVEL_SELECT)) begin
                // Prohibited codes are stored as written; upper bits read zero
                nxt_level = writedata[LEVEL_W-1:0];
            end
        end
    end

    // Detector outputs
    always_comb begin
        nxt_below_flag = ctrl_ff.enable & sync_below;
        nxt_reset_req  = ctrl_ff.enable & ctrl_ff.mode_reset & sync_below;
        nxt_irq        = ctrl_ff.enable & ~ctrl_ff.mode_reset & sync_below;
    end

    // Cause flags: a new event wins over a read clear
    always_comb begin
        nxt_cause = cause_ff;
        if (rd_acc && address == addr_of(IDX_RESET_CAUSE)) begin
            // Clear only what was returned, so a late event is not lost
            if (rdata_ff[CAUSE_WDT_BIT]) begin
                nxt_cause.wdt = 1'b0;
            end
            if (rdata_ff[CAUSE_LV_BIT]) begin
                nxt_cause.lowvolt = 1'b0;
            end
        end
        if (wdt_reset_req) begin
            nxt_cause.wdt = 1'b1;
        end
        if (lv_reset_event) begin
            nxt_cause.lowvolt = 1'b1;
        end
        if (por_clear_req) begin
            nxt_cause = rcl_cause_t'(2'b00);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_ff       <= rcl_ctrl_t'(CTRL_RESET[1:0]);
            cause_ff      <= rcl_cause_t'(CAUSE_RESET[1:0]);
            level_ff      <= LEVEL_RESET;
            below_flag_ff <= 1'b0;
            reset_req_ff  <= 1'b0;
            irq_ff        <= 1'b0;
        end else begin
            ctrl_ff       <= nxt_ctrl;
            cause_ff      <= nxt_cause;
            level_ff      <= nxt_level;
            below_flag_ff <= nxt_below_flag;
            reset_req_ff  <= nxt_reset_req;
            irq_ff        <= nxt_irq;
        end
    end

    assign lowvolt_reset_req  = reset_req_ff;
    assign lowvolt_irq        = irq_ff;
    assign lowvolt_level_code = level_ff;

    // Checks

    sequence s_below_held;
        (comparator_below && ctrl_ff.enable && !internal_clear)[*3];
    endsequence

    sequence s_cause_read_wdt;
        rd_acc && address == addr_of(IDX_RESET_CAUSE) && rdata_ff[CAUSE_WDT_BIT]
            && !wdt_reset_req && !por_clear_req;
    endsequence

    cause_read_clr_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        s_cause_read_wdt |=> !cause_ff.wdt)
        else $error("watchdog flag survived a read of the cause register");

    por_clear_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        por_clear_req |=> (!cause_ff.wdt && !cause_ff.lowvolt && !ctrl_ff.enable))
        else $error("power-on-clear left cause or control state set");

    wdt_flag_set_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        wdt_reset_req && !por_clear_req |=> cause_ff.wdt)
        else $error("watchdog reset did not set its cause flag");

    lv_flag_set_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        $rose(lowvolt_reset_req) && !$past(por_clear_req) |-> cause_ff.lowvolt)
        else $error("low-voltage reset did not set its cause flag");

    wdt_keeps_lv_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        wdt_reset_req && !por_clear_req && !rd_acc && !lv_reset_event
            |=> cause_ff.lowvolt == $past(cause_ff.lowvolt))
        else $error("watchdog reset disturbed the low-voltage cause flag");

    cause_reserved_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        rd_acc && address == addr_of(IDX_RESET_CAUSE)
            |-> (readdata & ~{24'h000000, CAUSE_MASK}) == 32'h00000000)
        else $error("reserved cause bits read as one");

    enable_write_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        wr_acc && address == addr_of(IDX_LOWVOLT_CONTROL) && !internal_clear
            |=> ctrl_ff.enable == $past(writedata[CTRL_ENABLE_BIT]))
        else $error("enable bit did not follow a byte write");

    bit_write_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        wr_acc && address == addr_of(IDX_LOWVOLT_BIT_WR) && bit_sel == BITSEL_MODE
            && !internal_clear |=> ctrl_ff.mode_reset == $past(bit_val))
        else $error("single-bit write missed the mode bit");

    flag_follows_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        ##1 below_flag_ff == $past(ctrl_ff.enable && sync_below))
        else $error("below-threshold flag does not track comparator and enable");

    irq_mode_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        lowvolt_irq |-> $past(!ctrl_ff.mode_reset && ctrl_ff.enable) && below_flag_ff)
        else $error("interrupt raised outside interrupt mode");

    reset_mode_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        ctrl_ff.enable && ctrl_ff.mode_reset && sync_below |=> lowvolt_reset_req)
        else $error("reset request missing in reset mode");

    sync_path_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        s_below_held |=> below_flag_ff)
        else $error("comparator level did not reach the flag in three cycles");

    ctrl_clear_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        wdt_reset_req |=> (!ctrl_ff.enable && !ctrl_ff.mode_reset && level_ff == LEVEL_RESET))
        else $error("watchdog reset left control or level state");

    bus_wait_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        req && !ack_ff |=> !waitrequest || !req)
        else $error("access not answered on the second cycle");

endmodule : rcl_reset_lowvolt

`default_nettype wire

// ### logic/rcl_sync2.sv
// Two-stage level synchroniser for one asynchronous input.
// Assumes the consumer reads only q; the first stage feeds nothing else.
`timescale 1ns/100ps
`default_nettype none

module rcl_sync2 (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Level in and out
    input  wire logic d,
    output logic      q
);
    logic stage1_ff;
    logic stage2_ff;
    logic nxt_stage1;
    logic nxt_stage2;

    always_comb begin
        nxt_stage1 = d;
        nxt_stage2 = stage1_ff;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1_ff <= 1'b0;
            stage2_ff <= 1'b0;
        end else begin
            stage1_ff <= nxt_stage1;
            stage2_ff <= nxt_stage2;
        end
    end

    assign q = stage2_ff;

endmodule : rcl_sync2

`default_nettype wire

// ### verif/rcl_chip_model.sv
// Model of the chip reset generator.
// Assumes the bench strobes fire_wdt or fire_por for one cycle on a rising edge.
`timescale 1ns/100ps
`default_nettype none

module rcl_chip_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Bench commands
    input  wire logic fire_wdt,
    input  wire logic fire_por,
    // Requests from the block
    input  wire logic lowvolt_reset_req,
    // Reset sources to the block
    output logic      wdt_reset_req,
    output logic      por_clear_req,
    // Count of low-voltage reset requests seen
    output var int    n_rst
);
    logic req_d_ff;

    // Sources are synchronous one-cycle pulses, as the block expects
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wdt_reset_req <= 1'b0;
            por_clear_req <= 1'b0;
        end else begin
            wdt_reset_req <= fire_wdt;
            por_clear_req <= fire_por;
        end
    end

    // Count survives resets so the bench can total the events
    // Plain always, since the initial value is a second writer
    initial n_rst = 0;
    always @(posedge clk) begin
        req_d_ff <= lowvolt_reset_req;
        if (lowvolt_reset_req === 1'b1 && req_d_ff !== 1'b1)
            n_rst <= n_rst + 1;
    end
endmodule : rcl_chip_model

`default_nettype wire

// ### verif/rcl_reset_lowvolt_bench.sv
// Self-checking bench for the reset-cause and low-voltage control block.
// Assumes one wait state on the bus and a three-cycle comparator path.
`timescale 1ns/100ps
`default_nettype none

module rcl_reset_lowvolt_bench import rcl_pkg::*;;
    logic               clk        = 1'b0;
    logic               reset_n    = 1'b0;
    logic [ADDR_W-1:0]  address    = '0;
    logic               read       = 1'b0;
    logic               write      = 1'b0;
    logic [DATA_W-1:0]  writedata  = '0;
    logic [3:0]         byteenable = 4'h0;
    logic               comparator_below = 1'b0;
    logic               fire_wdt   = 1'b0;
    logic               fire_por   = 1'b0;
    logic [DATA_W-1:0]  readdata;
    logic               waitrequest;
    logic               por_clear_req;
    logic               wdt_reset_req;
    logic [LEVEL_W-1:0] level_code;
    logic               lv_req;
    logic               lv_irq;
    logic [7:0]         code;
    logic [DATA_W-1:0]  exp_q[$];
    int                 n_rst;
    int                 n_errors   = 0;
    int                 num_checks = 0;
    int                 seed       = 32'hb73cd6ec;

    always #10 clk = ~clk;

    rcl_reset_lowvolt dut (
        .clk(clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .por_clear_req(por_clear_req),
        .wdt_reset_req(wdt_reset_req), .comparator_below(comparator_below),
        .lowvolt_level_code(level_code), .lowvolt_reset_req(lv_req), .lowvolt_irq(lv_irq)
    );

    rcl_chip_model chip (
        .clk(clk), .reset_n(reset_n), .fire_wdt(fire_wdt), .fire_por(fire_por),
        .lowvolt_reset_req(lv_req), .wdt_reset_req(wdt_reset_req),
        .por_clear_req(por_clear_req), .n_rst(n_rst)
    );

    task automatic chk(input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk

    // Request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] d,
                       input logic [3:0] be);
        @(posedge clk);
        address    <= {idx, 2'b00};
        read       <= ~wr;
        write      <= wr;
        writedata  <= {24'h000000, d};
        byteenable <= be;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        read  <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic rd(input logic [15:0] idx, input logic [7:0] e);
        exp_q.push_back({24'h000000, e});
        bus(1'b0, idx, 8'h00, 4'h1);
    endtask : rd

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 4'h1);
    endtask : wr

    task automatic cmp(input logic v);
        @(posedge clk);
        comparator_below <= v;
    endtask : cmp

    task automatic fire(input logic por);
        @(posedge clk);
        fire_por <= por;
        fire_wdt <= ~por;
        @(posedge clk);
        fire_por <= 1'b0;
        fire_wdt <= 1'b0;
    endtask : fire

    // Comparator path is three cycles; five leaves margin
    task automatic settle;
        repeat (5) @(posedge clk);
        #1;
    endtask : settle

    // Read data is taken at the edge where waitrequest is low
    always @(posedge clk) begin
        if (read === 1'b1 && waitrequest === 1'b0)
            chk(exp_q.pop_front(), readdata);
    end

    task automatic close_out;
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    initial begin
        // One settling wait plus the short scenarios, with room to spare
        repeat (2 * SETTLE_CYC) @(posedge clk);
        n_errors++;
        close_out();
    end

    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        rd(IDX_LOWVOLT_CONTROL, 8'h00);
        rd(IDX_LEVEL_SELECT, 8'h00);
        rd(IDX_RESET_CAUSE, 8'h00);
        rd(16'hff52, 8'h00);
        // Bits 6..2 stay zero; bit 0 is written only to show it is ignored
        wr(IDX_LOWVOLT_CONTROL, 8'h83);
        repeat (SETTLE_CYC) @(posedge clk);
        rd(IDX_LOWVOLT_CONTROL, 8'h82);
        bus(1'b1, IDX_LOWVOLT_CONTROL, 8'h00, 4'h0);
        rd(IDX_LOWVOLT_CONTROL, 8'h82);
        wr(IDX_LOWVOLT_BIT_WR, 8'h01);
        rd(IDX_LOWVOLT_CONTROL, 8'h80);
        for (int i = 0; i < 4; i++) begin
            code = 8'($unsigned($random(seed)) % 10);
            wr(IDX_LEVEL_SELECT, code);
            rd(IDX_LEVEL_SELECT, code);
            chk(code, level_code);
        end
        cmp(1'b1);
        @(posedge clk);
        #1;
        chk(1'b0, lv_irq);
        settle();
        chk(1'b1, lv_irq);
        chk(1'b0, lv_req);
        rd(IDX_LOWVOLT_CONTROL, 8'h81);
        wr(IDX_LOWVOLT_BIT_WR, 8'h07);
        settle();
        chk(1'b0, lv_irq);
        rd(IDX_LOWVOLT_CONTROL, 8'h00);
        wr(IDX_LOWVOLT_CONTROL, 8'h82);
        settle();
        chk(1'b1, lv_req);
        chk(1'b0, lv_irq);
        cmp(1'b0);
        settle();
        rd(IDX_RESET_CAUSE, 8'h01);
        rd(IDX_RESET_CAUSE, 8'h00);
        rd(IDX_LOWVOLT_CONTROL, 8'h82);
        fire(1'b0);
        settle();
        rd(IDX_LOWVOLT_CONTROL, 8'h00);
        wr(IDX_LOWVOLT_CONTROL, 8'h82);
        cmp(1'b1);
        settle();
        cmp(1'b0);
        settle();
        rd(IDX_RESET_CAUSE, 8'h11);
        rd(IDX_RESET_CAUSE, 8'h00);
        fire(1'b0);
        wr(IDX_RESET_CAUSE, 8'h00);
        rd(IDX_RESET_CAUSE, 8'h10);
        fire(1'b0);
        wr(IDX_LOWVOLT_CONTROL, 8'h80);
        fire(1'b1);
        settle();
        rd(IDX_RESET_CAUSE, 8'h00);
        rd(IDX_LOWVOLT_CONTROL, 8'h00);
        // Enable, then reset mode, through the single-bit port
        wr(IDX_LOWVOLT_BIT_WR, 8'h0f);
        wr(IDX_LOWVOLT_BIT_WR, 8'h09);
        rd(IDX_LOWVOLT_CONTROL, 8'h82);
        @(posedge clk);
        reset_n <= 1'b0;
        @(posedge clk);
        reset_n <= 1'b1;
        rd(IDX_LOWVOLT_CONTROL, 8'h00);
        chk(32'h00000002, n_rst);
        close_out();
    end
endmodule : rcl_reset_lowvolt_bench

`default_nettype wire
